/* File: sspsc_dev_end.sv */
// device phy end: reset sequence, spreading selection, align pacing
`timescale 1ns/100ps
// Overview of operation
// - both spreading kinds usable at every rate
// - disk phy accepts center, none, down input
// - non-disk phy on sata accepts sata ranges
// - oob detection unaffected by spread input
// - receiving stays good through both negotiations
// - end device: down if capable, else none
// - expander: center to ssc capable sas
// - expander: none to non-ssc sas
// - expander to sata transmits downspread
// - originated stream: at least 4/256 aligns when spreading
// - one programmable align rate for each of four contexts
// - forwarding expander inserts align on underflow
// - rate matching: no fixed align pattern
// - spreading off while sending oob
// - sata negotiation sent with spreading
// - windows one to three unspread
// - third window: low rate plus features
// - features carry ssc receive flag
// - final window at highest common rate
// - both capable: spread from start of final window
// - spreading held until next oob
module sspsc_dev_end (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  sspsc_link_if.dev_end                     lnk,
  input  wire logic                         is_expander,
  input  wire logic                         is_disk,
  input  wire logic [sspsc_pkg::RATE_W-1:0] my_rates,
  input  wire logic                         my_ssc_rx,
  input  wire logic                         link_reset_req,
  input  wire sspsc_pkg::sspsc_ctx_t        ctx,
  input  wire logic [7:0]                   align_rate [4],
  input  wire logic                         orig_valid,
  input  wire logic                         fwd_mode,
  input  wire logic                         fwd_valid,
  output sspsc_pkg::sspsc_step_t            step,
  output sspsc_pkg::sspsc_spread_t          spread_mode,
  output logic [sspsc_pkg::RATE_W-1:0]      neg_rate,
  output logic                              link_up,
  output logic                              dword_take,
  output logic                              align_ins,
  output sspsc_pkg::sspsc_type_t            att_type,
  output logic                              att_ssc,
  output logic [12:0]                       rx_tol_hi,
  output logic [12:0]                       rx_tol_lo
);
  import sspsc_pkg::*;

  logic [7:0]        sy1_reg;
  logic [7:0]        sy2_reg;
  sspsc_step_t       state_reg;
  sspsc_step_t       state_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic              cnt_done;
  logic              feat_reg;
  logic [RATE_W-1:0] frates_reg;
  logic [RATE_W-1:0] common;
  logic [3:0]        lcnt_reg;
  sspsc_spread_t     sel_mode;
  sspsc_type_t       sy_type;
  logic [CNT_W-1:0]  lim;
  logic [7:0]        eff;
  logic [9:0]        acc_reg;
  logic [9:0]        acc_sum;

  //////////////////////////////////////////////////////////////////////
  // synchronisers for far end pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sy1_reg <= 8'h00;
      sy2_reg <= 8'h00;
    end else begin
      sy1_reg <= {lnk.far_type, lnk.far_rates, lnk.far_ssc_rx,
                  lnk.far_feat_vld, lnk.far_sync_ok};
      sy2_reg <= sy1_reg;
    end
  end

  assign sy_type = sspsc_type_t'(sy2_reg[7:6]);

  //////////////////////////////////////////////////////////////////////
  // link clock divider
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lcnt_reg     <= 4'h0;
      lnk.dev_lclk <= 1'b0;
    end else if (lcnt_reg == LCLK_HALF - 4'h1) begin
      lcnt_reg     <= 4'h0;
      lnk.dev_lclk <= !lnk.dev_lclk;
    end else begin
      lcnt_reg <= lcnt_reg + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // reset and negotiation sequence
  always_comb begin
    unique case (state_reg)
      ST_OOB:   lim = CNT_W'(OOB_CYC - 1);
      ST_SATA:  lim = CNT_W'(SATA_CYC - 1);
      ST_FINAL: lim = CNT_W'(FINAL_CYC - 1);
      default:  lim = CNT_W'(WIN_CYC - 1);
    endcase
  end

  assign cnt_done = (cnt_reg == lim);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  state_next = ST_OOB;
      ST_OOB:   if (cnt_done)
                  state_next = (sy_type == PHY_SATA) ? ST_SATA : ST_WIN1;
      ST_SATA:  if (cnt_done) state_next = ST_UP;
      ST_WIN1:  if (cnt_done) state_next = ST_WIN2;
      ST_WIN2:  if (cnt_done) state_next = ST_WIN3;
      ST_WIN3:  if (cnt_done) state_next = feat_reg ? ST_FINAL : ST_OOB;
      ST_FINAL: if (cnt_done) state_next = ST_UP;
      ST_UP:    if (!sy2_reg[0]) state_next = ST_OOB;
    endcase
    if (link_reset_req && state_reg != ST_OOB)
      state_next = ST_OOB;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg || state_reg == ST_UP)
        cnt_reg <= '0;
      else if (!cnt_done)
        cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // attached phy type, features and final rate
  assign common = my_rates & frates_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      att_type   <= PHY_SAS;
      att_ssc    <= 1'b0;
      feat_reg   <= 1'b0;
      frates_reg <= 3'h0;
      neg_rate   <= 3'h0;
    end else begin
      if (state_reg == ST_OOB && cnt_done)
        att_type <= sy_type;
      if (state_next == ST_OOB && state_reg != ST_OOB)
        feat_reg <= 1'b0;
      else if (state_reg == ST_WIN3 && sy2_reg[1]) begin
        feat_reg   <= 1'b1;
        frates_reg <= sy2_reg[5:3];
        att_ssc    <= sy2_reg[2];
      end
      if (state_next == ST_FINAL && state_reg != ST_FINAL) begin
        if (common[RATE_G6])
          neg_rate <= 3'h4;
        else if (common[RATE_G3])
          neg_rate <= 3'h2;
        else
          neg_rate <= {2'h0, common[RATE_G15]};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // transmit spreading selection
  always_comb begin
    if (att_type == PHY_SATA)
      sel_mode = SPR_DOWN;
    else if (!(att_ssc && my_ssc_rx))
      sel_mode = SPR_NONE;
    else if (is_expander)
      sel_mode = SPR_CENTER;
    else
      sel_mode = SPR_DOWN;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      spread_mode    <= SPR_NONE;
      lnk.dev_spread <= SPR_NONE;
    end else begin
      unique case (state_next)
        ST_SATA: begin
          spread_mode    <= SPR_DOWN;
          lnk.dev_spread <= SPR_DOWN;
        end
        ST_FINAL: if (state_reg != ST_FINAL) begin
          spread_mode    <= sel_mode;
          lnk.dev_spread <= sel_mode;
        end
        ST_UP: ;
        ST_IDLE, ST_OOB, ST_WIN1, ST_WIN2, ST_WIN3: begin
          spread_mode    <= SPR_NONE;
          lnk.dev_spread <= SPR_NONE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // link outputs and receiver tolerance
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      step           <= ST_IDLE;
      link_up        <= 1'b0;
      lnk.dev_step   <= ST_IDLE;
      lnk.dev_rates  <= 3'h0;
      lnk.dev_ssc_rx <= 1'b0;
      rx_tol_hi      <= TOL_SAS_PPM;
      rx_tol_lo      <= TOL_SAS_PPM;
    end else begin
      step           <= state_next;
      link_up        <= (state_next == ST_UP);
      lnk.dev_step   <= state_next;
      lnk.dev_rates  <= my_rates;
      lnk.dev_ssc_rx <= my_ssc_rx;
      if (!is_disk && att_type == PHY_SATA) begin
        rx_tol_hi <= TOL_SATA_PPM;
        rx_tol_lo <= TOL_SDOWN_PPM;
      end else begin
        rx_tol_hi <= TOL_CENTER_PPM;
        rx_tol_lo <= TOL_DOWN_PPM;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // align insertion pacing
  always_comb begin
    eff = align_rate[ctx];
    if (spread_mode != SPR_NONE && eff < ALIGN_MIN_SSC)
      eff = ALIGN_MIN_SSC;
  end

  assign acc_sum = acc_reg + {2'h0, eff};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg    <= 10'h000;
      align_ins  <= 1'b0;
      dword_take <= 1'b0;
    end else if (state_next != ST_UP) begin
      acc_reg    <= 10'h000;
      align_ins  <= 1'b0;
      dword_take <= 1'b0;
    end else if (is_expander && fwd_mode) begin
      align_ins  <= !fwd_valid;
      dword_take <= fwd_valid;
    end else if (acc_sum >= ALIGN_WIN) begin
      acc_reg    <= acc_sum - ALIGN_WIN;
      align_ins  <= 1'b1;
      dword_take <= 1'b0;
    end else begin
      acc_reg    <= acc_sum;
      align_ins  <= 1'b0;
      dword_take <= orig_valid;
    end
  end
endmodule

/* File: sspsc_pkg.sv */
// shared constants and types for the ssc alignment control block
package sspsc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_OOB   = 3'b001,
    ST_SATA  = 3'b010,
    ST_WIN1  = 3'b011,
    ST_WIN2  = 3'b100,
    ST_WIN3  = 3'b101,
    ST_FINAL = 3'b110,
    ST_UP    = 3'b111
  } sspsc_step_t;
  typedef enum logic [1:0] {
    SPR_NONE   = 2'b00,
    SPR_DOWN   = 2'b01,
    SPR_CENTER = 2'b10
  } sspsc_spread_t;
  typedef enum logic [1:0] {
    PHY_SAS  = 2'b00,
    PHY_EXP  = 2'b01,
    PHY_SATA = 2'b10
  } sspsc_type_t;
  typedef enum logic [1:0] {
    CTX_OUT = 2'b00,
    CTX_SSP = 2'b01,
    CTX_SMP = 2'b10,
    CTX_STP = 2'b11
  } sspsc_ctx_t;
  localparam int RATE_W    = 3;
  localparam int RATE_G15  = 0;
  localparam int RATE_G3   = 1;
  localparam int RATE_G6   = 2;
  localparam int CLK_NS    = 10;
  localparam int OOB_NS    = 2000;
  localparam int SATA_NS   = 4000;
  localparam int WIN_NS    = 4000;
  localparam int FINAL_NS  = 4000;
  localparam int OOB_CYC   = (OOB_NS + CLK_NS - 1) / CLK_NS;
  localparam int SATA_CYC  = (SATA_NS + CLK_NS - 1) / CLK_NS;
  localparam int WIN_CYC   = (WIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int FINAL_CYC = (FINAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W     = 10;
  localparam logic [3:0] LCLK_HALF = 4'h6;
  localparam logic [7:0] ALIGN_MIN_SSC = 8'h04;
  localparam logic [9:0] ALIGN_WIN = 10'h100;
  localparam logic [12:0] TOL_CENTER_PPM = 13'h0A28;
  localparam logic [12:0] TOL_SAS_PPM    = 13'h0064;
  localparam logic [12:0] TOL_SATA_PPM   = 13'h015E;
  localparam logic [12:0] TOL_DOWN_PPM   = 13'h13EC;
  localparam logic [12:0] TOL_SDOWN_PPM  = 13'h14E6;
endpackage

/* File: sspsc_link_if.sv */
// link signals between the device phy end and the attached phy end
`timescale 1ns/100ps
interface sspsc_link_if;
  import sspsc_pkg::*;
  logic                dev_lclk;
  sspsc_step_t         dev_step;
  logic [RATE_W-1:0]   dev_rates;
  logic                dev_ssc_rx;
  sspsc_spread_t       dev_spread;
  sspsc_type_t         far_type;
  logic [RATE_W-1:0]   far_rates;
  logic                far_ssc_rx;
  logic                far_feat_vld;
  logic                far_sync_ok;
  sspsc_spread_t       far_spread;
  modport dev_end (
    output dev_lclk, dev_step, dev_rates, dev_ssc_rx, dev_spread,
    input  far_type, far_rates, far_ssc_rx, far_feat_vld, far_sync_ok,
           far_spread
  );
  modport far_end (
    input  dev_lclk, dev_step, dev_rates, dev_ssc_rx, dev_spread,
    output far_type, far_rates, far_ssc_rx, far_feat_vld, far_sync_ok,
           far_spread
  );
endinterface

/* File: sspsc_far_end.sv */
// attached phy end: feature exchange and its own transmit spreading
`timescale 1ns/100ps
module sspsc_far_end (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  sspsc_link_if.far_end                    lnk,
  input  wire sspsc_pkg::sspsc_type_t      my_type,
  input  wire logic [sspsc_pkg::RATE_W-1:0] my_rates,
  input  wire logic                        my_ssc_rx,
  input  wire logic                        sync_ok,
  output sspsc_pkg::sspsc_spread_t         spread_mode,
  output logic [sspsc_pkg::RATE_W-1:0]     neg_rate,
  output logic                             link_up
);
  import sspsc_pkg::*;

  logic [10:0]       sy1_reg;
  logic [10:0]       sy2_reg;
  logic              lclk_d_reg;
  sspsc_step_t       step_reg;
  logic [RATE_W-1:0] drates_reg;
  logic              dssc_reg;
  logic [RATE_W-1:0] common;
  sspsc_step_t       sy_step;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers and link clock edge sampling
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sy1_reg <= 11'h000;
      sy2_reg <= 11'h000;
    end else begin
      sy1_reg <= {lnk.dev_lclk, lnk.dev_step, lnk.dev_rates,
                  lnk.dev_ssc_rx, lnk.dev_spread, sync_ok};
      sy2_reg <= sy1_reg;
    end
  end

  assign sy_step = sspsc_step_t'(sy2_reg[9:7]);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lclk_d_reg <= 1'b0;
      step_reg   <= ST_IDLE;
      drates_reg <= 3'h0;
      dssc_reg   <= 1'b0;
    end else begin
      lclk_d_reg <= sy2_reg[10];
      if (sy2_reg[10] && !lclk_d_reg) begin
        step_reg   <= sy_step;
        drates_reg <= sy2_reg[6:4];
        dssc_reg   <= sy2_reg[3];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // feature answer in the third window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lnk.far_type     <= PHY_SAS;
      lnk.far_rates    <= 3'h0;
      lnk.far_ssc_rx   <= 1'b0;
      lnk.far_feat_vld <= 1'b0;
      lnk.far_sync_ok  <= 1'b0;
    end else begin
      lnk.far_type     <= my_type;
      lnk.far_rates    <= my_rates;
      lnk.far_ssc_rx   <= my_ssc_rx;
      lnk.far_feat_vld <= (step_reg == ST_WIN3);
      lnk.far_sync_ok  <= sy2_reg[0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // own spreading and final rate
  assign common = my_rates & drates_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      spread_mode    <= SPR_NONE;
      lnk.far_spread <= SPR_NONE;
      neg_rate       <= 3'h0;
      link_up        <= 1'b0;
    end else begin
      link_up <= (step_reg == ST_UP);
      if (common[RATE_G6])
        neg_rate <= 3'h4;
      else if (common[RATE_G3])
        neg_rate <= 3'h2;
      else
        neg_rate <= {2'h0, common[RATE_G15]};
      unique case (step_reg)
        ST_SATA: begin
          spread_mode    <= SPR_DOWN;
          lnk.far_spread <= SPR_DOWN;
        end
        ST_FINAL, ST_UP: begin
          if (my_type == PHY_SATA) begin
            spread_mode    <= SPR_DOWN;
            lnk.far_spread <= SPR_DOWN;
          end else if (my_ssc_rx && dssc_reg) begin
            spread_mode    <= (my_type == PHY_EXP) ? SPR_CENTER : SPR_DOWN;
            lnk.far_spread <= (my_type == PHY_EXP) ? SPR_CENTER : SPR_DOWN;
          end else begin
            spread_mode    <= SPR_NONE;
            lnk.far_spread <= SPR_NONE;
          end
        end
        ST_IDLE, ST_OOB, ST_WIN1, ST_WIN2, ST_WIN3: begin
          spread_mode    <= SPR_NONE;
          lnk.far_spread <= SPR_NONE;
        end
      endcase
    end
  end
endmodule

/* File: sspsc_properties.sv */
// concurrent checks on the link between the two phy ends
`timescale 1ns/100ps
module sspsc_properties (
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire sspsc_pkg::sspsc_step_t   dev_step,
  input wire sspsc_pkg::sspsc_spread_t dev_spread,
  input wire logic                    dev_ssc_rx,
  input wire logic                    far_ssc_rx,
  input wire sspsc_pkg::sspsc_type_t   far_type
);
  import sspsc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  sspsc_step_t       prev_reg;
  logic [CNT_W-1:0]  run_reg;
  // step of last cycle and length of its run
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_reg <= ST_IDLE;
      run_reg  <= '0;
    end else begin
      prev_reg <= dev_step;
      run_reg  <= (dev_step == prev_reg) ? run_reg + 1'b1 : 10'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  oob_no_spread_a: assert property (
    dev_step == ST_OOB && prev_reg == ST_OOB |-> dev_spread == SPR_NONE)
    else $error("spreading while sending oob");
  sata_down_a: assert property (
    dev_step == ST_SATA && prev_reg == ST_SATA |-> dev_spread == SPR_DOWN)
    else $error("sata negotiation not downspread");
  win_no_spread_a: assert property (
    dev_step inside {ST_WIN1, ST_WIN2, ST_WIN3} |-> dev_spread == SPR_NONE)
    else $error("spreading inside a window");
  oob_len_a: assert property (
    prev_reg == ST_OOB && dev_step != ST_OOB |-> run_reg == OOB_CYC)
    else $error("oob length wrong");
  win_len_a: assert property (
    prev_reg inside {ST_WIN1, ST_WIN2} && dev_step != prev_reg
    |-> run_reg == WIN_CYC && dev_step == prev_reg + 3'h1)
    else $error("window length or order wrong");
  final_entry_a: assert property (
    dev_step == ST_FINAL && prev_reg != ST_FINAL |-> prev_reg == ST_WIN3)
    else $error("final window not after third window");
  spread_held_a: assert property (
    dev_step == ST_UP && prev_reg == ST_UP |-> $stable(dev_spread))
    else $error("spreading changed while up");
  both_ssc_a: assert property (
    dev_step == ST_FINAL && prev_reg == ST_FINAL && dev_ssc_rx && far_ssc_rx
    |-> dev_spread != SPR_NONE)
    else $error("no spreading though both capable");
  no_ssc_a: assert property (
    dev_step == ST_FINAL && prev_reg == ST_FINAL
    && !(dev_ssc_rx && far_ssc_rx) |-> dev_spread == SPR_NONE)
    else $error("spreading though not both capable");
  sata_up_a: assert property (
    dev_step == ST_UP && prev_reg == ST_UP && far_type == PHY_SATA
    |-> dev_spread == SPR_DOWN)
    else $error("not downspread toward sata");
endmodule

/* File: sspsc_tb.sv */
// self-checking bench joining both phy ends
`timescale 1ns/100ps
module sspsc_tb;
  import sspsc_pkg::*;
  logic          clk;
  logic          nrst;
  logic          is_expander;
  logic          is_disk;
  logic [2:0]    dev_rates;
  logic          dev_ssc;
  logic          link_reset_req;
  sspsc_ctx_t    ctx;
  logic [7:0]    align_rate [4];
  logic          orig_valid;
  logic          fwd_mode;
  logic          fwd_valid;
  sspsc_type_t   far_type;
  logic [2:0]    far_rates;
  logic          far_ssc;
  logic          sync_ok;
  sspsc_step_t   step;
  sspsc_spread_t spread_mode;
  sspsc_spread_t f_spread;
  logic [2:0]    neg_rate;
  logic [2:0]    f_rate;
  logic          link_up;
  logic          f_up;
  logic          dword_take;
  logic          align_ins;
  sspsc_type_t   att_type;
  logic          att_ssc;
  logic [12:0]   rx_tol_hi;
  logic [12:0]   rx_tol_lo;
  int            fail_count;
  int            comparisons;
  ////////////////////////////////////////////////////////////////////////////
  sspsc_link_if lnk ();
  sspsc_dev_end i_sspsc_dev_end (.clk(clk), .nrst(nrst), .lnk(lnk),
    .is_expander(is_expander), .is_disk(is_disk), .my_rates(dev_rates),
    .my_ssc_rx(dev_ssc), .link_reset_req(link_reset_req), .ctx(ctx),
    .align_rate(align_rate), .orig_valid(orig_valid), .fwd_mode(fwd_mode),
    .fwd_valid(fwd_valid), .step(step), .spread_mode(spread_mode),
    .neg_rate(neg_rate), .link_up(link_up), .dword_take(dword_take),
    .align_ins(align_ins), .att_type(att_type), .att_ssc(att_ssc),
    .rx_tol_hi(rx_tol_hi), .rx_tol_lo(rx_tol_lo));
  sspsc_far_end i_sspsc_far_end (.clk(clk), .nrst(nrst), .lnk(lnk),
    .my_type(far_type), .my_rates(far_rates), .my_ssc_rx(far_ssc),
    .sync_ok(sync_ok), .spread_mode(f_spread), .neg_rate(f_rate),
    .link_up(f_up));
  sspsc_properties i_sspsc_properties (.clk(clk), .nrst(nrst),
    .dev_step(lnk.dev_step), .dev_spread(lnk.dev_spread),
    .dev_ssc_rx(lnk.dev_ssc_rx), .far_ssc_rx(lnk.far_ssc_rx),
    .far_type(lnk.far_type));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic logic [1:0] exp_spread(input logic ex, input logic s,
                                            input sspsc_type_t t,
                                            input logic fs);
    if (t == PHY_SATA) return SPR_DOWN;
    if (s && fs) return ex ? SPR_CENTER : SPR_DOWN;
    return SPR_NONE;
  endfunction
  function automatic logic [2:0] top_rate(input logic [2:0] r);
    for (int b = 2; b >= 0; b--) if (r[b]) return 3'(1 << b);
    return 3'h0;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // one link bring-up with a given attached phy, then traffic, then drop
  task automatic run_cfg(input int i);
    int k;
    int na;
    int nt;
    int z;
    int r;
    logic v;
    logic sat;
    logic [1:0] es;
    sspsc_type_t t;
    t = (i == 2) ? PHY_SATA : (i < 4) ? PHY_SAS
        : sspsc_type_t'(2'($urandom_range(2)));
    nrst <= 1'b0;
    is_expander <= (i < 4) ? !i[0] : 1'($urandom);
    is_disk <= 1'($urandom);
    dev_ssc <= (i < 4) ? 1'b1 : 1'($urandom);
    far_ssc <= (i < 3) ? 1'b1 : (i == 3) ? 1'b0 : 1'($urandom);
    far_type <= t;
    dev_rates <= {2'($urandom), 1'b1};
    far_rates <= {2'($urandom), 1'b1};
    ctx <= sspsc_ctx_t'(i[1:0]);
    for (k = 0; k < 4; k++)
      align_rate[k] <= (i == 0) ? 8'h01 : 8'($urandom_range(40));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (k = 0; k < 6000 && link_up !== 1'b1; k++) @(negedge clk);
    // far end sees the step only after sync and a link clock edge
    repeat (20) @(negedge clk);
    es = exp_spread(is_expander, dev_ssc, t, far_ssc);
    sat = !is_disk && t == PHY_SATA;
    check(link_up, 1'b1);
    check(f_up, 1'b1);
    check(spread_mode, es);
    check(f_spread, exp_spread(t == PHY_EXP, far_ssc, t, dev_ssc));
    check(att_type, t);
    check(att_ssc, far_ssc && t != PHY_SATA);
    if (t != PHY_SATA)
      check(neg_rate, top_rate(dev_rates & far_rates));
    if (t != PHY_SATA)
      check(f_rate, top_rate(dev_rates & far_rates));
    check(rx_tol_hi, sat ? TOL_SATA_PPM : TOL_CENTER_PPM);
    check(rx_tol_lo, sat ? TOL_SDOWN_PPM : TOL_DOWN_PPM);
    r = align_rate[ctx];
    if (es != SPR_NONE && r < 4)
      r = 4;
    na = 0;
    nt = 0;
    for (k = 0; k < 256; k++) begin
      @(negedge clk);
      na += align_ins;
      nt += dword_take;
    end
    check(na, r);
    check(nt, 256 - r);
    if (is_expander) begin
      @(posedge clk);
      fwd_mode <= 1'b1;
      fwd_valid <= 1'b1;
      repeat (4) @(posedge clk);
      na = 0;
      nt = 0;
      z = 0;
      for (k = 0; k < 68; k++) begin
        @(posedge clk);
        v = (k < 64) ? 1'($urandom) : 1'b1;
        fwd_valid <= v;
        z += !v;
        @(negedge clk);
        na += align_ins;
        nt += dword_take;
      end
      check(na, z);
      check(nt, 68 - z);
      @(posedge clk);
      fwd_mode <= 1'b0;
    end
    @(posedge clk);
    if (i[0]) link_reset_req <= 1'b1;
    else sync_ok <= 1'b0;
    @(posedge clk);
    link_reset_req <= 1'b0;
    for (k = 0; k < 50 && step !== ST_OOB; k++) @(negedge clk);
    @(negedge clk);
    check(step, ST_OOB);
    check(spread_mode, SPR_NONE);
    @(posedge clk);
    sync_ok <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    is_expander = 1'b0;
    is_disk = 1'b0;
    dev_rates = 3'h1;
    dev_ssc = 1'b0;
    link_reset_req = 1'b0;
    ctx = CTX_OUT;
    for (int j = 0; j < 4; j++) align_rate[j] = 8'h00;
    orig_valid = 1'b1;
    fwd_mode = 1'b0;
    fwd_valid = 1'b0;
    far_type = PHY_SAS;
    far_rates = 3'h1;
    far_ssc = 1'b0;
    sync_ok = 1'b1;
    fail_count = 0;
    comparisons = 0;
    void'($urandom(32'h0717));
    for (int i = 0; i < 8; i++) run_cfg(i);
    summarize();
  end
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule
